// ### design/spp_consts.vh
// Constants for the strobed parallel port: field positions, codes, reset values
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH
`define SPP_IN_FULL_BIT      0
`define SPP_OUT_FULL_BIT     1
`define SPP_IN_EDGE_SEL_BIT  2
`define SPP_CLR_EDGE_SEL_BIT 3
`define SPP_PIN_A_MODE_LO    4
`define SPP_PIN_A_MODE_HI    5
`define SPP_PIN_B_MODE_LO    6
`define SPP_PIN_B_MODE_HI    7
`define SPP_CTRL_RESET       6'h3f
`define SPP_CSR_RESET        8'hfc
`define SPP_PIN_DRIVE_LOW    2'h0
`define SPP_PIN_DRIVE_HIGH   2'h1
`define SPP_PIN_SHOW_FLAG    2'h2
`define SPP_PIN_INPUT        2'h3
`define SPP_DATA_WIDTH       8
`endif

// ### design/spp_buffer.v
// Two-entry valid/ready buffer between the input latch and the CPU
`timescale 1ns/1ns
`include "spp_consts.vh"
module spp_buffer
(
	input  wire                       clk,
	input  wire                       reset,
	input  wire                       in_valid,
	output wire                       in_ready,
	input  wire [`SPP_DATA_WIDTH-1:0] in_data,
	output wire                       out_valid,
	input  wire                       out_ready,
	output wire [`SPP_DATA_WIDTH-1:0] out_data
);
	reg [`SPP_DATA_WIDTH-1:0] mem [0:1];	// Two flop entries
	reg                       rd_ptr;		// Index of head entry
	reg                       wr_ptr;		// Index of next free entry
	reg [1:0]                 count;		// Words held, 0..2
	wire                      push;
	wire                      pop;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and count update; push and pop may share a cycle
	always @(posedge clk)
	begin
		if (reset)
		begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count  <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push & ~pop)
				count <= count + 2'h1;
			else if (pop & ~push)
				count <= count - 2'h1;
		end
	end
endmodule

// ### design/spp_port.v
// Strobed 8-bit parallel port with two strobes, two flag pins and a control/status register
`timescale 1ns/1ns
`include "spp_consts.vh"
module spp_port
(
	CLK,
	RESET,
	CPU_WR_DATA,
	CPU_WR_CSR,
	CPU_WDATA,
	CPU_RD_DATA,
	OUTPUT_ALWAYS,
	CSR_RDATA,
	IN_DATA,
	IN_VALID,
	PORT_IN,
	PORT_OUT,
	PORT_OE,
	OUTPUT_STROBE_N,
	INPUT_STROBE_N,
	STATUS_PIN_A_IN,
	STATUS_PIN_A_OUT,
	STATUS_PIN_A_OE,
	STATUS_PIN_B_IN,
	STATUS_PIN_B_OUT,
	STATUS_PIN_B_OE
);
	input  wire       CLK;
	input  wire       RESET;
	input  wire       CPU_WR_DATA;
	input  wire       CPU_WR_CSR;
	input  wire [7:0] CPU_WDATA;
	input  wire       CPU_RD_DATA;
	input  wire       OUTPUT_ALWAYS;
	output reg  [7:0] CSR_RDATA;
	output reg  [7:0] IN_DATA;
	output reg        IN_VALID;
	input  wire [7:0] PORT_IN;
	output reg  [7:0] PORT_OUT;
	output reg        PORT_OE;
	input  wire       OUTPUT_STROBE_N;
	input  wire       INPUT_STROBE_N;
	input  wire       STATUS_PIN_A_IN;
	output reg        STATUS_PIN_A_OUT;
	output reg        STATUS_PIN_A_OE;
	input  wire       STATUS_PIN_B_IN;
	output reg        STATUS_PIN_B_OUT;
	output reg        STATUS_PIN_B_OE;

	// Writable configuration, bits 7..2 of the control/status register
	reg  [5:0] ctrl;
	// Status flags, bits 1..0
	reg        out_buffer_full;
	reg        in_buffer_full;
	// Output data buffer written by the CPU
	reg  [7:0] out_data;
	// Input latch between pins and the two-entry buffer
	reg  [7:0] in_latch;

	// First synchroniser stage; read only by the second stage
	reg  [7:0] port_meta;
	reg        ods_meta;
	reg        ids_meta;
	reg        pin_a_meta;
	reg        pin_b_meta;
	// Second synchroniser stage; safe for logic
	reg  [7:0] port_sync;
	reg        ods_sync;
	reg        ids_sync;
	reg        pin_a_sync;
	reg        pin_b_sync;
	// Previous strobe levels for edge detection
	reg        ods_prev;
	reg        ids_prev;

	// Decoded configuration fields
	wire       input_strobe_edge_sel;
	wire       out_full_clear_edge_sel;
	wire [1:0] pin_a_mode;
	wire [1:0] pin_b_mode;
	wire [7:0] port_control_status;

	// Strobe edges and gating
	wire       ods_rise;
	wire       ods_fall;
	wire       ids_rise;
	wire       ids_fall;
	wire       port_enable_input;
	wire       port_disabled;
	wire       clear_edge;
	wire       set_edge;
	wire       load_edge;

	// Buffer signals
	wire       buf_in_ready;
	wire       buf_out_valid;
	wire [7:0] buf_out_data;
	wire       buf_pop;
	reg        push_pending;
	reg        buf_single;         // Exactly one word sits in the buffer
	reg  [1:0] buf_count;          // Mirror of the buffer occupancy
	reg  [1:0] next_buf_count;     // Occupancy after this cycle
	wire       buf_count_next_one; // Next occupancy is one word

	// Next values of the pin-facing outputs
	reg  [7:0] next_port_out;
	reg        next_port_oe;
	reg        next_pin_a_out;
	reg        next_pin_a_oe;
	reg        next_pin_b_out;
	reg        next_pin_b_oe;

	// Drive level for a flag pin from its two mode bits
	function pin_level;
		input [1:0] mode;
		input       flag;
		begin
			case (mode)
				`SPP_PIN_DRIVE_LOW:  pin_level = 1'b0;
				`SPP_PIN_DRIVE_HIGH: pin_level = 1'b1;
				`SPP_PIN_SHOW_FLAG:  pin_level = flag;
				default:             pin_level = 1'b0;
			endcase
		end
	endfunction

	assign input_strobe_edge_sel   = ctrl[`SPP_IN_EDGE_SEL_BIT-2];
	assign out_full_clear_edge_sel = ctrl[`SPP_CLR_EDGE_SEL_BIT-2];
	// Pin A mode in bits 5:4
	assign pin_a_mode = ctrl[`SPP_PIN_A_MODE_HI-2:`SPP_PIN_A_MODE_LO-2];
	// Pin B mode in bits 7:6
	assign pin_b_mode = ctrl[`SPP_PIN_B_MODE_HI-2:`SPP_PIN_B_MODE_LO-2];
	// Status flags occupy the low two bits
	assign port_control_status = {ctrl, out_buffer_full, in_buffer_full};

	// Edge detectors look only at the second stage
	assign ods_rise = ods_sync & ~ods_prev;
	assign ods_fall = ~ods_sync & ods_prev;
	assign ids_rise = ids_sync & ~ids_prev;
	assign ids_fall = ~ids_sync & ids_prev;

	// Pin B as active-low enable; high shuts the strobes out
	assign port_enable_input = (pin_b_mode == `SPP_PIN_INPUT);
	assign port_disabled     = port_enable_input & pin_b_sync;

	// Clearing edge of the output strobe, chosen by bit 3
	assign clear_edge = ~port_disabled &
		(out_full_clear_edge_sel ? ods_rise : ods_fall);

	// In-full set edge: falling in transparent mode, rising otherwise
	assign set_edge = ~port_disabled &
		(input_strobe_edge_sel ? ids_fall : ids_rise);

	// The latch always closes on the rising edge, so the word is pushed the cycle after it
	assign load_edge = ~port_disabled & ids_rise;

	// CPU read consumes the head word of the buffer
	assign buf_pop = CPU_RD_DATA & buf_out_valid;

	// Two-flop synchronisers on every pin input
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			port_meta  <= 8'h00;
			port_sync  <= 8'h00;
			ods_meta   <= 1'b1;
			ods_sync   <= 1'b1;
			ods_prev   <= 1'b1;
			ids_meta   <= 1'b1;
			ids_sync   <= 1'b1;
			ids_prev   <= 1'b1;
			pin_a_meta <= 1'b0;
			pin_a_sync <= 1'b0;
			pin_b_meta <= 1'b0;
			pin_b_sync <= 1'b0;
		end
		else
		begin
			port_meta  <= PORT_IN;
			port_sync  <= port_meta;
			ods_meta   <= OUTPUT_STROBE_N;
			ods_sync   <= ods_meta;
			ods_prev   <= ods_sync;
			ids_meta   <= INPUT_STROBE_N;
			ids_sync   <= ids_meta;
			ids_prev   <= ids_sync;
			pin_a_meta <= STATUS_PIN_A_IN;
			pin_a_sync <= pin_a_meta;
			pin_b_meta <= STATUS_PIN_B_IN;
			pin_b_sync <= pin_b_meta;
		end
	end

	// Configuration bits; CPU writes never reach the two flag bits
	always @(posedge CLK)
	begin
		if (RESET)
			ctrl <= `SPP_CTRL_RESET;
		else if (CPU_WR_CSR)
			ctrl <= CPU_WDATA[7:2];
	end

	// Output buffer and its full flag
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			out_data        <= 8'h00;
			out_buffer_full <= 1'b0;
		end
		else
		begin
			if (CPU_WR_DATA)
				out_data <= CPU_WDATA;
			// A write in the clearing cycle wins, so no byte goes unflagged
			if (CPU_WR_DATA)
				out_buffer_full <= 1'b1;
			else if (clear_edge)
				out_buffer_full <= 1'b0;
		end
	end

	// Input latch: transparent while the strobe is low in mode 1,
	// sampled on the rising edge in mode 0
	always @(posedge CLK)
	begin
		if (RESET)
			in_latch <= 8'h00;
		else if (~port_disabled & buf_in_ready)
		begin
			if (input_strobe_edge_sel & ~ids_sync)
				in_latch <= port_sync;
			else if (~input_strobe_edge_sel & ids_rise)
				in_latch <= port_sync;
		end
	end

	// The transparent latch already holds the word at the rising edge;
	// in edge mode it lands one cycle later, so the push is delayed a cycle
	always @(posedge CLK)
	begin
		if (RESET)
			push_pending <= 1'b0;
		else
			push_pending <= load_edge & buf_in_ready;
	end

	// In-full flag: set by the chosen strobe edge, cleared by a read
	// unless another word still waits; a set in the read cycle wins
	always @(posedge CLK)
	begin
		if (RESET)
			in_buffer_full <= 1'b0;
		else if (set_edge & buf_in_ready)
			in_buffer_full <= 1'b1;
		else if (CPU_RD_DATA)
			in_buffer_full <= push_pending | (buf_out_valid & buf_pop &
				~buf_single);
	end

	// True when exactly one word sits in the buffer
	always @(posedge CLK)
	begin
		if (RESET)
			buf_single <= 1'b0;
		else
			buf_single <= buf_count_next_one;
	end

	// Tracks occupancy so the flag knows whether a read empties it
	assign buf_count_next_one = (next_buf_count == 2'h1);
	always @*
	begin
		next_buf_count = buf_count;
		if (push_pending & ~buf_pop)
			next_buf_count = buf_count + 2'h1;
		else if (buf_pop & ~push_pending)
			next_buf_count = buf_count - 2'h1;
	end
	always @(posedge CLK)
	begin
		if (RESET)
			buf_count <= 2'h0;
		else
			buf_count <= next_buf_count;
	end

	// Two-entry buffer so a late CPU read loses no byte; when full the
	// input latch stops following the strobe instead of overwriting
	spp_buffer u_buffer
	(
		.clk       (CLK),
		.reset     (RESET),
		.in_valid  (push_pending),
		.in_ready  (buf_in_ready),
		.in_data   (in_latch),
		.out_valid (buf_out_valid),
		.out_ready (CPU_RD_DATA),
		.out_data  (buf_out_data)
	);

	// Data pins: drivers and source selection
	always @*
	begin
		next_port_out = out_data;
		next_port_oe  = 1'b0;
		// Select input on pin A: high shows the status register
		if (pin_a_mode == `SPP_PIN_INPUT && pin_a_sync)
			next_port_out = port_control_status;
		if (port_disabled)
			next_port_oe = 1'b0;
		else if (OUTPUT_ALWAYS)
			next_port_oe = 1'b1;
		else
			next_port_oe = ~ods_sync;
	end

	// Flag pin A: static level, out-full, or input
	always @*
	begin
		next_pin_a_out = pin_level(pin_a_mode, out_buffer_full);
		next_pin_a_oe  = (pin_a_mode != `SPP_PIN_INPUT);
	end

	// Flag pin B: static level, in-full, or enable input
	always @*
	begin
		next_pin_b_out = pin_level(pin_b_mode, in_buffer_full);
		next_pin_b_oe  = (pin_b_mode != `SPP_PIN_INPUT);
	end

	// Registered outputs; reset leaves every pin released
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			PORT_OUT         <= 8'h00;
			PORT_OE          <= 1'b0;
			STATUS_PIN_A_OUT <= 1'b0;
			STATUS_PIN_A_OE  <= 1'b0;
			STATUS_PIN_B_OUT <= 1'b0;
			STATUS_PIN_B_OE  <= 1'b0;
			CSR_RDATA        <= `SPP_CSR_RESET;
			IN_DATA          <= 8'h00;
			IN_VALID         <= 1'b0;
		end
		else
		begin
			PORT_OUT         <= next_port_out;
			PORT_OE          <= next_port_oe;
			STATUS_PIN_A_OUT <= next_pin_a_out;
			STATUS_PIN_A_OE  <= next_pin_a_oe;
			STATUS_PIN_B_OUT <= next_pin_b_out;
			STATUS_PIN_B_OE  <= next_pin_b_oe;
			CSR_RDATA        <= port_control_status;
			IN_DATA          <= buf_out_data;
			IN_VALID         <= buf_out_valid & ~buf_pop;
		end
	end
endmodule

// ### sim/spp_port_sva.sv
// Assertions on the strobed parallel port pins
`timescale 1ns/1ns
module spp_port_sva
(
	input wire       CLK,
	input wire       RESET,
	input wire       CPU_WR_DATA,
	input wire       CPU_WR_CSR,
	input wire [7:0] CPU_WDATA,
	input wire       OUTPUT_ALWAYS,
	input wire [7:0] CSR_RDATA,
	input wire [7:0] PORT_OUT,
	input wire       PORT_OE,
	input wire       OUTPUT_STROBE_N,
	input wire       STATUS_PIN_A_IN,
	input wire       STATUS_PIN_A_OUT,
	input wire       STATUS_PIN_A_OE,
	input wire       STATUS_PIN_B_IN,
	input wire       STATUS_PIN_B_OUT,
	input wire       STATUS_PIN_B_OE
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	full_on_write_a: assert property (CPU_WR_DATA |-> ##[1:2] CSR_RDATA[1])
		else $error("full flag not set by write");
	csr_write_a: assert property (CPU_WR_CSR ##1 !CPU_WR_CSR |->
		##1 CSR_RDATA[7:2] == $past(CPU_WDATA[7:2], 2)) else $error("config not stored");
	reset_value_a: assert property (disable iff (1'b0) RESET |=> CSR_RDATA == 8'hfc)
		else $error("bad reset value");
	// Stable mode lets either output latency pass
	pin_a_out_a: assert property (CSR_RDATA[5:4] != 2'h3 && $stable(CSR_RDATA) |->
		STATUS_PIN_A_OE && STATUS_PIN_A_OUT == (CSR_RDATA[5:4] == 2'h1
		|| CSR_RDATA[5:4] == 2'h2 && CSR_RDATA[1])) else $error("pin a wrong");
	pin_b_out_a: assert property (CSR_RDATA[7:6] != 2'h3 && $stable(CSR_RDATA) |->
		STATUS_PIN_B_OE && STATUS_PIN_B_OUT == (CSR_RDATA[7:6] == 2'h1
		|| CSR_RDATA[7:6] == 2'h2 && CSR_RDATA[0])) else $error("pin b wrong");
	flag_inputs_a: assert property ($stable(CSR_RDATA) |->
		(CSR_RDATA[5:4] != 2'h3 || !STATUS_PIN_A_OE) && (CSR_RDATA[7:6] != 2'h3
		|| !STATUS_PIN_B_OE)) else $error("input pin driven");
	port_float_a: assert property ((CSR_RDATA[7:6] == 2'h3 && STATUS_PIN_B_IN)[*5]
		|-> !PORT_OE) else $error("drives while disabled");
	strobe_off_a: assert property ((!OUTPUT_ALWAYS && OUTPUT_STROBE_N)[*5] |-> !PORT_OE)
		else $error("drives without strobe");
	drive_on_a: assert property (((OUTPUT_ALWAYS || !OUTPUT_STROBE_N)
		&& CSR_RDATA[7:6] != 2'h3)[*5] |-> PORT_OE) else $error("drivers off");
	select_status_a: assert property ((CSR_RDATA[5:4] == 2'h3 && STATUS_PIN_A_IN
		&& $stable(CSR_RDATA))[*5] |-> !PORT_OE || PORT_OUT == CSR_RDATA)
		else $error("status not shown");
endmodule
bind spp_port spp_port_sva chk (.*);

// ### sim/spp_host.sv
// Far-side host model: strobes, flag pins and port pins with pull-ups
`timescale 1ns/1ns
module spp_host
(
	input  wire       clk,
	input  wire [7:0] port_out,
	input  wire       port_oe,
	input  wire       a_out,
	input  wire       a_oe,
	input  wire       b_out,
	input  wire       b_oe,
	output wire [7:0] port_in,
	output wire       a_in,
	output wire       b_in,
	output reg        ods_n = 1'b0,
	output reg        ids_n = 1'b0
);
	reg [7:0] data = 8'h00; // Host byte on the port pins
	reg       d_en = 1'b0;  // Host drives the port pins
	reg [1:0] a = 2'h2;     // Pin A {drive, level}; grounded from power-up
	reg [1:0] b = 2'h2;     // Pin B {drive, level}
	// Undriven lines rise to the pull-up level, never keep old data
	assign port_in = port_oe ? port_out : (d_en ? data : 8'hff);
	assign a_in    = a_oe ? a_out : (a[1] ? a[0] : 1'b1);
	assign b_in    = b_oe ? b_out : (b[1] ? b[0] : 1'b1);
	// New pin state just after an edge
	task set(input o, input i, input [1:0] na, input [1:0] nb, input de, input [7:0] nd);
	begin
		@(posedge clk) #1;
		ods_n = o;
		ids_n = i;
		a = na;
		b = nb;
		d_en = de;
		data = nd;
	end
	endtask
endmodule

// ### sim/spp_testbench.sv
// Self-checking bench for the strobed parallel port
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
	reg        CLK = 1'b0;
	reg        RESET = 1'b1;
	reg        CPU_WR_DATA = 1'b0;
	reg        CPU_WR_CSR = 1'b0;
	reg        CPU_RD_DATA = 1'b0;
	reg        OUTPUT_ALWAYS = 1'b0;
	reg  [7:0] CPU_WDATA = 8'h00;
	wire [7:0] CSR_RDATA, IN_DATA, PORT_IN, PORT_OUT;
	wire       IN_VALID, PORT_OE, OUTPUT_STROBE_N, INPUT_STROBE_N;
	wire       STATUS_PIN_A_IN, STATUS_PIN_A_OUT, STATUS_PIN_A_OE;
	wire       STATUS_PIN_B_IN, STATUS_PIN_B_OUT, STATUS_PIN_B_OE;
	int        n_tests = 0;
	int        n_mismatch = 0;
	int        k;
	reg  [7:0] v, d, x;
	reg  [7:0] q[$];   // Bytes the CPU should read back, oldest first
	spp_port DUT (.*);
	spp_host host
	(
		.clk      (CLK),
		.port_out (PORT_OUT),
		.port_oe  (PORT_OE),
		.a_out    (STATUS_PIN_A_OUT),
		.a_oe     (STATUS_PIN_A_OE),
		.b_out    (STATUS_PIN_B_OUT),
		.b_oe     (STATUS_PIN_B_OE),
		.port_in  (PORT_IN),
		.a_in     (STATUS_PIN_A_IN),
		.b_in     (STATUS_PIN_B_IN),
		.ods_n    (OUTPUT_STROBE_N),
		.ids_n    (INPUT_STROBE_N)
	);
	always #20 CLK = ~CLK;
	// Each CPU read takes the oldest noted byte; pre-edge values are the popped head
	always @(posedge CLK)
	begin
		if (CPU_RD_DATA && IN_VALID)
		begin
			x = q.size() ? q.pop_front() : 8'hxx;
			`CHK("in_data", x, IN_DATA)
		end
	end
	task tally_and_finish;
	begin
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	// One-cycle CPU strobe {write data, write config, read}
	task cpu(input [2:0] c, input [7:0] w);
	begin
		@(posedge CLK) #1;
		{CPU_WR_DATA, CPU_WR_CSR, CPU_RD_DATA} = c;
		CPU_WDATA = w;
		@(posedge CLK) #1;
		{CPU_WR_DATA, CPU_WR_CSR, CPU_RD_DATA} = 3'h0;
	end
	endtask
	// Covers two synchroniser flops, edge detect and output register
	task settle;
	begin
		repeat (8) @(posedge CLK);
		#1;
	end
	endtask
	// Pop only once the head is shown, bounded
	task pop;
	begin
		repeat (2) @(posedge CLK);
		#1;
		for (int i = 0; IN_VALID !== 1'b1; i++)
		begin
			if (i == 50)
			begin
				n_mismatch++;
				tally_and_finish;
			end
			@(posedge CLK) #1;
		end
		cpu(3'h1, 8'h00);
	end
	endtask
	// Host strobes one byte in with pin B held as given
	task send(input [7:0] w, input [1:0] b);
	begin
		host.set(1, 0, 2'h0, b, 1, w);
		settle;
		host.set(1, 1, 2'h0, b, 1, w);
		settle;
	end
	endtask
	initial
	begin
		#3000000;
		n_mismatch++;
		tally_and_finish;
	end
	initial
	begin
		v = 8'($urandom(32'h890f));
		repeat (3) @(posedge CLK);
		#1;
		RESET = 1'b0;
		`CHK("csr", 8'hfc, CSR_RDATA)
		`CHK("oe", 3'h0, {PORT_OE, STATUS_PIN_A_OE, STATUS_PIN_B_OE})
		// Grounded control pins: plain port both ways
		d = 8'($urandom);
		cpu(3'h4, d);
		settle;
		`CHK("plain", {1'b1, d}, {PORT_OE, PORT_OUT})
		q.push_back(d);
		host.set(1, 1, 2'h2, 2'h2, 0, 8'h00);
		settle;
		pop;
		host.set(1, 1, 2'h0, 2'h0, 0, 8'h00);
		settle;
		v = 8'($urandom);
		cpu(3'h2, v | 8'h03);
		settle;
		`CHK("csr", {v[7:2], 2'h0}, CSR_RDATA)
		for (k = 0; k < 2; k++)
		begin
			cpu(3'h2, {1'b0, k[0], 1'b0, k[0], 4'h0});
			settle;
			`CHK("pins", {k[0], k[0]}, {STATUS_PIN_A_OUT, STATUS_PIN_B_OUT})
		end
		// Output byte, cleared by either strobe edge
		for (k = 0; k < 2; k++)
		begin
			cpu(3'h2, {4'ha, k[0], 3'h0});
			d = 8'($urandom);
			cpu(3'h4, d);
			settle;
			`CHK("full", 2'h3, {CSR_RDATA[1], STATUS_PIN_A_OUT})
			host.set(0, 1, 2'h0, 2'h0, 0, 8'h00);
			settle;
			`CHK("drive", {1'b1, d}, {PORT_OE, PORT_OUT})
			`CHK("low", k[0], CSR_RDATA[1])
			host.set(1, 1, 2'h0, 2'h0, 0, 8'h00);
			settle;
			`CHK("high", 2'h0, {CSR_RDATA[1], PORT_OE})
		end
		// Input byte; junk first while low, then the real byte
		for (k = 0; k < 2; k++)
		begin
			cpu(3'h2, {4'ha, 1'b0, k[0], 2'h0});
			v = 8'($urandom);
			q.push_back(v);
			host.set(1, 0, 2'h0, 2'h0, 1, ~v);
			settle;
			`CHK("early", k[0], CSR_RDATA[0])
			send(v, 2'h0);
			`CHK("set", 2'h3, {CSR_RDATA[0], STATUS_PIN_B_OUT})
			pop;
			settle;
			`CHK("clear", 2'h0, {CSR_RDATA[0], STATUS_PIN_B_OUT})
		end
		// Fill the buffer past its two words, then drain it
		for (k = 0; k < 3; k++)
		begin
			v = 8'($urandom);
			if (k < 2)
				q.push_back(v);
			send(v, 2'h0);
		end
		pop;
		pop;
		settle;
		`CHK("drain", 2'h0, {IN_VALID, CSR_RDATA[0]})
		// Pin B as port enable
		cpu(3'h2, 8'he0);
		send(8'($urandom), 2'h3);
		`CHK("ignored", 1'b0, CSR_RDATA[0])
		host.set(0, 1, 2'h0, 2'h3, 0, 8'h00);
		settle;
		`CHK("float", 1'b0, PORT_OE)
		host.set(0, 1, 2'h0, 2'h2, 0, 8'h00);
		settle;
		`CHK("enabled", 1'b1, PORT_OE)
		v = 8'($urandom);
		q.push_back(v);
		send(v, 2'h2);
		pop;
		// Pin A as data or status select
		cpu(3'h2, 8'hf0);
		host.set(0, 1, 2'h3, 2'h2, 0, 8'h00);
		settle;
		`CHK("status", 8'hf0, PORT_OUT)
		host.set(0, 1, 2'h2, 2'h2, 0, 8'h00);
		settle;
		`CHK("data", d, PORT_OUT)
		host.set(1, 1, 2'h0, 2'h0, 0, 8'h00);
		cpu(3'h2, 8'ha0);
		OUTPUT_ALWAYS = 1'b1;
		settle;
		`CHK("always", 1'b1, PORT_OE)
		OUTPUT_ALWAYS = 1'b0;
		settle;
		`CHK("left", 0, q.size())
		tally_and_finish;
	end
endmodule
